// ===== src/pis_pkg.sv
// pis_pkg: constants, enums and carrier structs of the interrupt-source block
// assumes a 200 MHz system clock; all timing counts derive from it here
package pis_pkg;
    localparam int CLK_MHZ      = 200;
    localparam int SE0_MIN_NS   = 12000;  // bus reset may be seen from here
    localparam int SE0_MAX_NS   = 16000;  // and must be seen by here
    localparam int SE0_CYC      = (SE0_MIN_NS * CLK_MHZ + 999) / 1000;
    localparam int SE0_MAX_CYC  = (SE0_MAX_NS * CLK_MHZ) / 1000;
    localparam int TICK_A_NS    = 128000;   // 128 us tick
    localparam int TICK_B_NS    = 1024000;  // 1.024 ms tick
    localparam int TICK_A_CYC   = (TICK_A_NS / 1000) * CLK_MHZ;
    localparam int TICK_B_CYC   = (TICK_B_NS / 1000) * CLK_MHZ;
    localparam int N_EP         = 5;
    localparam int N_SRC        = 11;
    // pending vector positions, in vector order
    localparam int SRC_BUSRST   = 0;
    localparam int SRC_TICK_A   = 1;
    localparam int SRC_TICK_B   = 2;
    localparam int SRC_EP0      = 3;
    localparam int SRC_DAC      = 8;
    localparam int SRC_GPIO     = 9;
    localparam int SRC_I2C      = 10;
    // enable positions inside the global enable byte
    localparam int GIE_BUSRST   = 0;
    localparam int GIE_TICK_A   = 1;
    localparam int GIE_TICK_B   = 2;
    localparam int GIE_DAC      = 4;
    localparam int GIE_GPIO     = 5;
    localparam int GIE_I2C      = 6;
    localparam int STAT_BUSRST  = 5;  // status bit that records a bus reset

    typedef enum logic [2:0] {
        PIS_IDLE  = 3'h1,
        PIS_SE0   = 3'h2,
        PIS_RESET = 3'h4
    } pis_rst_e;

    // events from the i2c byte engine and firmware writes, all one-cycle pulses
    typedef struct packed {
        logic slave_rx_byte;
        logic first_byte;
        logic slave_stop;
        logic ack_cleared;
        logic slave_tx_byte;
        logic master_acked;
        logic master_tx_byte;
        logic master_rx_byte;
        logic arb_lost;
        logic bus_stop;
        logic fw_write;
        logic fw_continue;
        logic fw_master;
    } pis_i2c_ev_s;

    // i2c status bits presented back to firmware
    typedef struct packed {
        logic busy;
        logic master_select;
        logic arbitration_lost_flag;
        logic addr_flag;
        logic stop_flag;
        logic master_ack;
        logic stop_request;
    } pis_i2c_st_s;
endpackage : pis_pkg

// ===== src/pis_irq.sv
// pis_irq: interrupt sources feeding the core's pending flip-flops
// assumes usb, dac and gpio pins are asynchronous; all other inputs are
// pulses or levels on clk from the core, the serial engine and the i2c engine

// Function
// - se0 of 12 to 16 us means bus reset
// - bus reset sets status bit five
// - bus reset interrupt when se0 ends
// - bus reset aborts power-on start-up delay
// - bus reset clears both device address registers
// - two periodic ticks, 128 us and 1.024 ms
// - five endpoint interrupts on final acknowledge
// - dac pins interrupt on programmed edge
// - dac pins share one vector
// - first dac pin locks out others
// - dac pins unprioritised, enables survive acknowledge
// - gpio pins interrupt, per-port polarity, one vector
// - first gpio pin locks out others
// - gpio pins unprioritised, enables survive acknowledge
// - host port owns gpio vector when enabled
// - pin enables still steer cmos mode
// - slave receive, transmit, stop interrupts
// - master byte interrupts; clearing master issues stop
// - arbitration loss clears master, waits stop
// - busy cleared before conditions one to four
module pis_irq
    import pis_pkg::*;
#(
    parameter int N_DAC      = 8,
    parameter int N_GPIO     = 32,
    parameter int TICK_A     = TICK_A_CYC,
    parameter int TICK_B     = TICK_B_CYC
)(
    input  wire logic              clk,
    input  wire logic              sys_rst,
    input  wire logic              usb_dp,
    input  wire logic              usb_dm,
    input  wire logic              por_delay_active,
    input  wire logic              bus_reset_seen_clr,
    input  wire logic [N_EP-1:0]   ep_in_host_ack,
    input  wire logic [N_EP-1:0]   ep_out_dev_ack,
    input  wire logic [N_DAC-1:0]  dac_pin,
    input  wire logic [N_DAC-1:0]  dac_polarity,
    input  wire logic [N_DAC-1:0]  dac_pin_ie,
    input  wire logic [N_GPIO-1:0] gpio_pin,
    input  wire logic [N_GPIO/8-1:0] gpio_port_polarity,
    input  wire logic [N_GPIO-1:0] gpio_pin_ie,
    input  wire logic              host_port_enable,
    input  wire logic              host_port_event,
    input  wire pis_i2c_ev_s       i2c_ev,
    input  wire logic [7:0]        global_ie,
    input  wire logic [N_EP-1:0]   ep_ie,
    input  wire logic [N_SRC-1:0]  irq_ack,
    output logic [7:0]             usb_status,
    output logic                   por_delay_abort,
    output logic                   addr_clear,
    output logic [N_GPIO-1:0]      gpio_cmos_ie,
    output pis_i2c_st_s            i2c_status,
    output logic [N_SRC-1:0]       irq_pending,
    output logic [N_SRC-1:0]       irq_request
);
    localparam int TA_W = $clog2(TICK_A + 1);
    localparam int TB_W = $clog2(TICK_B + 1);
    localparam int SE_W = $clog2(SE0_CYC + 1);
    localparam int NP   = N_GPIO / 8;

    // pins that the block cannot serve are refused at elaboration
    if (N_DAC < 1 || N_GPIO < 8 || N_GPIO % 8 != 0 || TICK_A < 2 || TICK_B < 2)
    begin : g_bad_param
        $error("pis_irq: unsupported pin count or tick length");
    end

    typedef struct packed {
        logic [1:0]        usb_dp_s;
        logic [1:0]        usb_dm_s;
        logic [N_DAC-1:0]  dac_s1;
        logic [N_DAC-1:0]  dac_s2;
        logic [N_DAC-1:0]  dac_act;
        logic [N_DAC-1:0]  dac_lock;
        logic [N_GPIO-1:0] gpio_s1;
        logic [N_GPIO-1:0] gpio_s2;
        logic [N_GPIO-1:0] gpio_act;
        logic [N_GPIO-1:0] gpio_lock;
        pis_rst_e          rst_st;
        logic [SE_W-1:0]   se0_cnt;
        logic              seen;
        logic              abort;
        logic              aclr;
        logic [TA_W-1:0]   tick_a;
        logic [TB_W-1:0]   tick_b;
        pis_i2c_st_s       i2c;
        logic              arb_wait;
        logic              i2c_ev_d;
        logic [N_GPIO-1:0] cmos_ie;
        logic [N_SRC-1:0]  pend;
    } pis_state_s;

    pis_state_s q;
    pis_state_s next_q;

    logic             se0;
    logic [N_SRC-1:0] ev;
    logic [N_DAC-1:0] dac_now;
    logic [N_GPIO-1:0] gpio_now;
    logic             dac_ev;
    logic             gpio_ev;
    logic             i2c_ev_now;

    // second sync stage only feeds logic; the first is read by nothing else
    assign se0 = ~q.usb_dp_s[1] & ~q.usb_dm_s[1];

    always_comb
    begin
        next_q     = q;
        ev         = '0;
        dac_ev     = 1'b0;
        gpio_ev    = 1'b0;
        i2c_ev_now = 1'b0;
        next_q.abort = 1'b0;
        next_q.aclr  = 1'b0;
        next_q.i2c.stop_request = 1'b0;

        // two-flop synchronisers on every pin
        next_q.usb_dp_s = {q.usb_dp_s[0], usb_dp};
        next_q.usb_dm_s = {q.usb_dm_s[0], usb_dm};
        next_q.dac_s1   = dac_pin;
        next_q.dac_s2   = q.dac_s1;
        next_q.gpio_s1  = gpio_pin;
        next_q.gpio_s2  = q.gpio_s1;

        // bus reset detector: counts se0, then waits for its release
        case (q.rst_st)
            PIS_IDLE:
            begin
                next_q.se0_cnt = '0;
                if (se0)
                    next_q.rst_st = PIS_SE0;
            end
            PIS_SE0:
            begin
                if (!se0)
                    next_q.rst_st = PIS_IDLE;
                else if (q.se0_cnt == SE_W'(SE0_CYC - 2))
                begin
                    next_q.rst_st = PIS_RESET;
                    next_q.seen   = 1'b1;
                    next_q.aclr   = 1'b1;
                    next_q.abort  = por_delay_active;
                end
                else
                    next_q.se0_cnt = q.se0_cnt + SE_W'(1);
            end
            PIS_RESET:
            begin
                if (!se0)
                begin
                    next_q.rst_st   = PIS_IDLE;
                    ev[SRC_BUSRST]  = 1'b1;
                end
            end
            default: next_q.rst_st = PIS_IDLE;
        endcase
        // firmware clear loses against a fresh detection
        if (bus_reset_seen_clr && !next_q.aclr)
            next_q.seen = 1'b0;

        // free-running periodic ticks; firmware masks them before suspend
        next_q.tick_a = (q.tick_a == TA_W'(TICK_A - 1)) ? '0 : q.tick_a + TA_W'(1);
        next_q.tick_b = (q.tick_b == TB_W'(TICK_B - 1)) ? '0 : q.tick_b + TB_W'(1);
        ev[SRC_TICK_A] = (q.tick_a == TA_W'(TICK_A - 1));
        ev[SRC_TICK_B] = (q.tick_b == TB_W'(TICK_B - 1));

        // endpoint events: host ack on in, device ack on out only
        ev[SRC_EP0 +: N_EP] = ep_in_host_ack | ep_out_dev_ack;

        // dac: per-pin polarity, single owner until it drops or is disabled
        dac_now        = ~(q.dac_s2 ^ dac_polarity) & dac_pin_ie;
        next_q.dac_act = dac_now;
        next_q.dac_lock = q.dac_lock & dac_now;
        for (int i = 0; i < N_DAC; i++)
        begin
            if (dac_now[i] && !q.dac_act[i] && next_q.dac_lock == '0 && !dac_ev)
            begin
                next_q.dac_lock[i] = 1'b1;
                dac_ev = 1'b1;
            end
        end
        ev[SRC_DAC] = dac_ev;

        // gpio: per-port polarity, same lockout, host port steals the vector
        for (int i = 0; i < N_GPIO; i++)
            gpio_now[i] = ~(q.gpio_s2[i] ^ gpio_port_polarity[i/8]) & gpio_pin_ie[i];
        next_q.gpio_act  = gpio_now;
        next_q.gpio_lock = q.gpio_lock & gpio_now;
        for (int i = 0; i < N_GPIO; i++)
        begin
            if (gpio_now[i] && !q.gpio_act[i] && next_q.gpio_lock == '0
                && !gpio_ev && !host_port_enable)
            begin
                next_q.gpio_lock[i] = 1'b1;
                gpio_ev = 1'b1;
            end
        end
        ev[SRC_GPIO] = host_port_enable ? host_port_event : gpio_ev;
        next_q.cmos_ie = gpio_pin_ie;

        // i2c engine: busy drops on the event edge except on master receive and the bus stop after arbitration loss, pending follows one edge later
        if (i2c_ev.slave_rx_byte)
        begin
            next_q.i2c.busy      = 1'b0;
            next_q.i2c.addr_flag = i2c_ev.first_byte;
            i2c_ev_now = 1'b1;
        end
        if (i2c_ev.slave_stop && !i2c_ev.ack_cleared)
        begin
            next_q.i2c.busy      = 1'b0;
            next_q.i2c.stop_flag = 1'b1;
            i2c_ev_now = 1'b1;
        end
        if (i2c_ev.slave_tx_byte)
        begin
            next_q.i2c.busy       = 1'b0;
            next_q.i2c.master_ack = i2c_ev.master_acked;
            i2c_ev_now = 1'b1;
        end
        if (i2c_ev.master_tx_byte)
        begin
            next_q.i2c.busy = 1'b0;
            i2c_ev_now = 1'b1;
        end
        if (i2c_ev.master_rx_byte)
            i2c_ev_now = 1'b1;
        // a single firmware write restarts the engine after each interrupt
        if (i2c_ev.fw_write)
        begin
            next_q.i2c.busy      = i2c_ev.fw_continue;
            next_q.i2c.stop_flag = i2c_ev.slave_stop && !i2c_ev.ack_cleared;  // set wins
            next_q.i2c.arbitration_lost_flag = 1'b0;
            next_q.i2c.master_select = i2c_ev.fw_master;
            if (q.i2c.master_select && !i2c_ev.fw_master)
                next_q.i2c.stop_request = 1'b1;
        end
        // arbitration loss wins over the write and waits for the bus stop
        if (i2c_ev.arb_lost)
        begin
            next_q.i2c.master_select         = 1'b0;
            next_q.i2c.arbitration_lost_flag = 1'b1;
            next_q.i2c.stop_request          = 1'b0;
            next_q.arb_wait                  = 1'b1;
        end
        else if (q.arb_wait && i2c_ev.bus_stop)
        begin
            next_q.arb_wait = 1'b0;
            i2c_ev_now = 1'b1;
        end
        next_q.i2c_ev_d = i2c_ev_now;
        ev[SRC_I2C]     = q.i2c_ev_d;

        // pending flops: a new event wins over an acknowledge in the same cycle
        next_q.pend = (q.pend & ~irq_ack) | ev;
    end

    // one register stage for the whole state; constants only under reset
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            q        <= '0;
            q.rst_st <= PIS_IDLE;
            q.usb_dp_s <= 2'h3;  // idle bus is j, so no false se0 follows reset
        end
        else
            q <= next_q;
    end

    // request lines are pending gated by the enable registers, kept by the core
    assign irq_request = q.pend & {global_ie[GIE_I2C], global_ie[GIE_GPIO],
                                   global_ie[GIE_DAC], ep_ie,
                                   global_ie[GIE_TICK_B], global_ie[GIE_TICK_A],
                                   global_ie[GIE_BUSRST]};
    assign irq_pending     = q.pend;
    assign usb_status      = {2'h0, q.seen, 5'h00};
    assign por_delay_abort = q.abort;
    assign addr_clear      = q.aclr;
    assign gpio_cmos_ie    = q.cmos_ie;
    assign i2c_status      = q.i2c;

    // checks on the detector and sources
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    sequence s_se0_run;
        se0 [*8];
    endsequence
    sequence s_se0_end;
        (q.rst_st == PIS_RESET) ##1 !se0;
    endsequence

    a_state_onehot: assert property ($onehot(q.rst_st))
        else $error("reset detector state not one-hot");
    a_reset_window: assert property (
        $rose(q.aclr) |-> $past(q.rst_st) == PIS_SE0 && q.se0_cnt <= SE_W'(SE0_MAX_CYC))
        else $error("bus reset declared outside window");
    a_reset_status: assert property ($rose(q.aclr) |-> usb_status[STAT_BUSRST])
        else $error("status bit not set on bus reset");
    a_reset_irq_end: assert property (
        s_se0_end |=> irq_pending[SRC_BUSRST])
        else $error("bus reset interrupt missing at se0 release");
    a_reset_irq_none: assert property (
        s_se0_run ##0 (q.rst_st == PIS_RESET) |=> $stable(irq_pending[SRC_BUSRST])
                                                  || !se0 || $past(irq_ack[SRC_BUSRST]))
        else $error("bus reset interrupt during se0");
    a_abort_por: assert property (por_delay_abort |-> addr_clear)
        else $error("start-up abort without bus reset");
    a_tick_a: assert property (
        (q.tick_a == TA_W'(TICK_A - 1)) |=> irq_pending[SRC_TICK_A])
        else $error("short tick lost");
    a_ep_event: assert property (
        (ep_in_host_ack[0] || ep_out_dev_ack[0]) |=> irq_pending[SRC_EP0])
        else $error("endpoint event lost");
    a_dac_lock: assert property ($onehot0(q.dac_lock))
        else $error("two dac pins own the vector");
    a_gpio_host: assert property (
        host_port_enable |=> q.gpio_lock == '0 || $past(q.gpio_lock) != '0)
        else $error("gpio pin took vector from host port");
    a_host_event: assert property (
        host_port_enable && host_port_event |=> irq_pending[SRC_GPIO])
        else $error("host port event lost");
    a_i2c_busy: assert property (
        q.i2c_ev_d && !$past(q.arb_wait) && !$past(i2c_ev.master_rx_byte)
        |-> !q.i2c.busy || $past(i2c_ev.fw_write))
        else $error("busy still set at i2c interrupt");
    a_slave_stop: assert property (
        i2c_ev.slave_stop && !i2c_ev.ack_cleared |=> i2c_status.stop_flag)
        else $error("stop flag not set on slave stop");
    a_arb_lost: assert property (
        i2c_ev.arb_lost |=> !i2c_status.master_select
                            && i2c_status.arbitration_lost_flag)
        else $error("arbitration loss not recorded");
    a_pend_ack: assert property (irq_ack[SRC_I2C] && !q.i2c_ev_d |=> !irq_pending[SRC_I2C])
        else $error("pending flop not cleared by acknowledge");
endmodule // pis_irq

// ===== sim/pis_core_model.sv
// pis_core_model: stand-in for the cpu core that services interrupt requests
// assumes irq_request is settled before clk rises; acks are one-cycle pulses
module pis_core_model
    import pis_pkg::*;
#(
    parameter int GAP = 2
)(
    input  wire logic             clk,
    input  wire logic             sys_rst,
    input  wire logic             svc,
    input  wire logic [N_SRC-1:0] irq_request,
    output logic      [N_SRC-1:0] irq_ack
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [3:0] wait_cnt;

    // ack the lowest-numbered request, the highest priority one;
    // the pause stands in for the call, so a cleared flop settles before the next pick
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            irq_ack  <= '0;
            wait_cnt <= '0;
        end
        else if (wait_cnt != 4'h0)
        begin
            irq_ack  <= '0;
            wait_cnt <= wait_cnt - 4'h1;
        end
        else if (svc && irq_request != '0)
        begin
            irq_ack  <= irq_request & (~irq_request + N_SRC'(1));
            wait_cnt <= 4'(GAP);
        end
        else
            irq_ack <= '0;
    end
endmodule // pis_core_model

// ===== sim/test_peripheral_interrupt_sources.sv
// test_peripheral_interrupt_sources: directed bench for pis_irq
// assumes pis_pkg and pis_core_model compiled first; inputs change 1 ns after clk rises
module test_peripheral_interrupt_sources
    import pis_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int NG = 16;
    localparam int TA = 16;
    localparam int TB = 40;

    logic              clk, sys_rst, usb_dp, usb_dm, por_delay_active;
    logic              bus_reset_seen_clr, host_port_enable, host_port_event, svc;
    logic              por_delay_abort, addr_clear;
    logic [N_EP-1:0]   ep_in_host_ack, ep_out_dev_ack, ep_ie;
    logic [7:0]        dac_pin, dac_polarity, dac_pin_ie, global_ie, usb_status;
    logic [NG-1:0]     gpio_pin, gpio_pin_ie, gpio_cmos_ie;
    logic [NG/8-1:0]   gpio_port_polarity;
    logic [N_SRC-1:0]  irq_ack, irq_pending, irq_request, prev_pend;
    pis_i2c_ev_s       i2c_ev, ev;
    pis_i2c_st_s       i2c_status;
    logic              prev_busy;
    int                failures, tests_run, cyc, n, c;
    int                rise_at [N_SRC];
    int                rise_gap [N_SRC];

    pis_irq #(.N_DAC(8), .N_GPIO(NG), .TICK_A(TA), .TICK_B(TB)) dut (
        .clk(clk), .sys_rst(sys_rst), .usb_dp(usb_dp), .usb_dm(usb_dm),
        .por_delay_active(por_delay_active), .bus_reset_seen_clr(bus_reset_seen_clr),
        .ep_in_host_ack(ep_in_host_ack), .ep_out_dev_ack(ep_out_dev_ack),
        .dac_pin(dac_pin), .dac_polarity(dac_polarity), .dac_pin_ie(dac_pin_ie),
        .gpio_pin(gpio_pin), .gpio_port_polarity(gpio_port_polarity),
        .gpio_pin_ie(gpio_pin_ie), .host_port_enable(host_port_enable),
        .host_port_event(host_port_event), .i2c_ev(i2c_ev), .global_ie(global_ie),
        .ep_ie(ep_ie), .irq_ack(irq_ack), .usb_status(usb_status),
        .por_delay_abort(por_delay_abort), .addr_clear(addr_clear),
        .gpio_cmos_ie(gpio_cmos_ie), .i2c_status(i2c_status),
        .irq_pending(irq_pending), .irq_request(irq_request));

    pis_core_model core (.clk(clk), .sys_rst(sys_rst), .svc(svc),
        .irq_request(irq_request), .irq_ack(irq_ack));

    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic results();
        $display("comparisons %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic step(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            failures++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    // bounded wait, since a missing pending bit must not hang the run
    task automatic wait_pend(input int idx, input int lim);
        for (int k = 0; k < lim && irq_pending[idx] !== 1'b1; k++) step(1);
        check("pending set", irq_pending[idx], 1'b1);
    endtask

    task automatic service(input int idx);
        svc = 1'b1;
        step(1);
        for (int k = 0; k < 20 && irq_pending[idx] !== 1'b0; k++) step(1);
        svc = 1'b0;
        check("pending cleared", irq_pending[idx], 1'b0);
    endtask

    task automatic i2c_pulse(input pis_i2c_ev_s e);
        i2c_ev = e;
        step(1);
        i2c_ev = '0;
    endtask

    // edge history of the pending flops; also the hang limit (run is about 5000 cycles)
    always @(posedge clk)
    begin
        cyc       <= cyc + 1;
        prev_pend <= irq_pending;
        prev_busy <= i2c_status.busy;
        for (int i = 0; i < N_SRC; i++)
            if (irq_pending[i] === 1'b1 && prev_pend[i] === 1'b0)
            begin
                rise_gap[i] <= cyc - rise_at[i];
                rise_at[i]  <= cyc;
            end
        if (cyc == 20000)
        begin
            failures++;
            results();
        end
    end

    initial
    begin
        {sys_rst, usb_dp} = 2'b11;
        {usb_dm, por_delay_active, bus_reset_seen_clr, svc} = '0;
        {host_port_enable, host_port_event, ep_in_host_ack, ep_out_dev_ack} = '0;
        {ep_ie, global_ie, dac_polarity, dac_pin_ie, gpio_pin_ie} = '0;
        {failures, tests_run, cyc} = '0;
        dac_pin = 8'h02;
        gpio_pin = 16'hff00;
        gpio_port_polarity = 2'h1;
        i2c_ev = '0;
        prev_busy = 1'b0;
        prev_pend = '0;
        rise_at = '{default: 0};
        rise_gap = '{default: 0};
        repeat (5) @(posedge clk);
        #1 sys_rst = 1'b0;
        step(1);
        check("pending after reset", irq_pending, 32'h0);
        check("status after reset", usb_status, 32'h0);
        // endpoints: in then out, first with the endpoint enable off
        for (c = 0; c < 2 * N_EP; c++)
        begin
            ep_ie = '0;
            if (c < N_EP) ep_in_host_ack[c] = 1'b1;
            else ep_out_dev_ack[c - N_EP] = 1'b1;
            step(1);
            {ep_in_host_ack, ep_out_dev_ack} = '0;
            check("ep pending", irq_pending[SRC_EP0 + c % N_EP], 1'b1);
            check("ep masked", irq_request[SRC_EP0 + c % N_EP], 1'b0);
            ep_ie = 5'h1f;
            #1 check("ep request", irq_request[SRC_EP0 + c % N_EP], 1'b1);
            service(SRC_EP0 + c % N_EP);
        end
        // periodic ticks serviced as they come
        global_ie = 8'h06;
        svc = 1'b1;
        step(3 * TB);
        check("tick a period", rise_gap[SRC_TICK_A], TA);
        check("tick b period", rise_gap[SRC_TICK_B], TB);
        global_ie = 8'h00;
        svc = 1'b0;
        // se0 of 10 us must not count as a bus reset
        por_delay_active = 1'b1;
        global_ie = 8'h01;
        usb_dp = 1'b0;
        for (n = 0; n < 2000 && addr_clear !== 1'b1; n++) step(1);
        usb_dp = 1'b1;
        step(10);
        check("short se0", {addr_clear, usb_status[STAT_BUSRST]}, 2'b00);
        usb_dp = 1'b0;
        for (n = 0; n < 3300 && addr_clear !== 1'b1; n++) step(1);
        check("se0 window", n >= SE0_CYC && n <= SE0_MAX_CYC, 1'b1);
        check("status bit", usb_status[STAT_BUSRST], 1'b1);
        check("delay abort", por_delay_abort, 1'b1);
        step(1);
        check("addr clear pulse", {addr_clear, por_delay_abort}, 2'b00);
        step(100);
        check("no irq during se0", irq_pending[SRC_BUSRST], 1'b0);
        usb_dp = 1'b1;
        wait_pend(SRC_BUSRST, 6);
        service(SRC_BUSRST);
        bus_reset_seen_clr = 1'b1;
        step(1);
        bus_reset_seen_clr = 1'b0;
        por_delay_active = 1'b0;
        step(1);
        check("status cleared", usb_status[STAT_BUSRST], 1'b0);
        // dac: pin0 rising, pin1 falling; the owner locks the other out
        global_ie = 8'h10;
        dac_polarity = 8'h01;
        dac_pin_ie = 8'h03;
        step(4);
        dac_pin = 8'h03;
        wait_pend(SRC_DAC, 5);
        service(SRC_DAC);
        dac_pin = 8'h01;
        step(6);
        check("dac locked", irq_pending[SRC_DAC], 1'b0);
        dac_pin = 8'h00;
        step(4);
        service(SRC_DAC);
        dac_pin = 8'h02;
        step(4);
        dac_pin = 8'h00;
        wait_pend(SRC_DAC, 5);
        service(SRC_DAC);
        dac_pin = 8'h01;
        step(6);
        check("dac lock after ack", irq_pending[SRC_DAC], 1'b0);
        // gpio: pin3 on the rising port, pin9 on the falling port
        global_ie = 8'h20;
        gpio_pin_ie = 16'h0208;
        step(4);
        check("cmos enables", gpio_cmos_ie, 16'h0208);
        gpio_pin = 16'hff08;
        wait_pend(SRC_GPIO, 5);
        service(SRC_GPIO);
        check("cmos kept", gpio_cmos_ie, 16'h0208);
        gpio_pin = 16'hfd08;
        step(6);
        check("gpio locked", irq_pending[SRC_GPIO], 1'b0);
        gpio_pin_ie = 16'h0200;
        step(4);
        service(SRC_GPIO);
        gpio_pin = 16'hff00;
        step(4);
        gpio_pin = 16'hfd00;
        wait_pend(SRC_GPIO, 5);
        service(SRC_GPIO);
        // host port owns the vector and blocks pin events
        host_port_enable = 1'b1;
        gpio_pin = 16'hff00;
        step(4);
        gpio_pin = 16'hfd00;
        step(6);
        check("pins blocked", irq_pending[SRC_GPIO], 1'b0);
        host_port_event = 1'b1;
        step(1);
        host_port_event = 1'b0;
        wait_pend(SRC_GPIO, 4);
        global_ie = 8'h00;
        #1 check("host gated", irq_request[SRC_GPIO], 1'b0);
        check("cmos with host", gpio_cmos_ie, 16'h0200);
        global_ie = 8'h20;
        service(SRC_GPIO);
        host_port_enable = 1'b0;
        // i2c conditions 1 to 5, each after one firmware write setting busy
        global_ie = 8'h40;
        for (c = 0; c < 5; c++)
        begin
            ev = '0;
            ev.fw_write = 1'b1;
            ev.fw_continue = 1'b1;
            ev.fw_master = (c >= 3);
            i2c_pulse(ev);
            step(1);
            ev = '0;
            case (c)
                0: ev.slave_rx_byte = 1'b1;
                1: ev.slave_stop = 1'b1;
                2: ev.slave_tx_byte = 1'b1;
                3: ev.master_tx_byte = 1'b1;
                default: ev.master_rx_byte = 1'b1;
            endcase
            ev.first_byte = (c == 0);
            ev.master_acked = (c == 2);
            i2c_pulse(ev);
            wait_pend(SRC_I2C, 4);
            check("busy before irq", prev_busy, c == 4);
            if (c == 0) check("addr flag", i2c_status.addr_flag, 1'b1);
            if (c == 1) check("stop flag", i2c_status.stop_flag, 1'b1);
            if (c == 2) check("master ack", i2c_status.master_ack, 1'b1);
            service(SRC_I2C);
        end
        ev = '0;
        ev.slave_stop = 1'b1;
        ev.ack_cleared = 1'b1;
        i2c_pulse(ev);
        step(5);
        check("stop after nack", irq_pending[SRC_I2C], 1'b0);
        ev = '0;
        ev.fw_write = 1'b1;
        i2c_pulse(ev);
        for (n = 0; n < 4 && i2c_status.stop_request !== 1'b1; n++) step(1);
        check("stop request", i2c_status.stop_request, 1'b1);
        step(1);
        ev.fw_master = 1'b1;
        ev.fw_continue = 1'b1;
        i2c_pulse(ev);
        step(1);
        ev = '0;
        ev.arb_lost = 1'b1;
        i2c_pulse(ev);
        step(1);
        check("arb master", i2c_status.master_select, 1'b0);
        check("arb flag", i2c_status.arbitration_lost_flag, 1'b1);
        step(6);
        check("arb waits stop", irq_pending[SRC_I2C], 1'b0);
        ev = '0;
        ev.bus_stop = 1'b1;
        i2c_pulse(ev);
        wait_pend(SRC_I2C, 4);
        results();
    end
endmodule // test_peripheral_interrupt_sources
